// File: core/timer_pkg.sv
// constants, register map and state types of the prescaled reload timer
// assumes a 250 MHz bus clock and a 13.56 MHz timer reference derived from it
package timer_pkg;

  // ==========================================================
  // clocks
  localparam int REF_FREQ_KHZ = 13560;
  localparam int CLK_FREQ_KHZ = 250000;
  // one bit above the modulus so acc plus step never wraps
  localparam int ACC_WIDTH = 19;
  localparam logic [ACC_WIDTH-1:0] REF_STEP = ACC_WIDTH'(REF_FREQ_KHZ);
  localparam logic [ACC_WIDTH-1:0] REF_MOD = ACC_WIDTH'(CLK_FREQ_KHZ);

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h2a;
  localparam logic [7:0] IDX_DIV_LOW = 8'h2b;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h2c;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h2d;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h2e;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h2f;
  localparam logic [7:0] IDX_CONFIG = 8'h38;
  localparam logic [7:0] IDX_CONTROL = 8'h39;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h3a;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h3b;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 9;

  // ==========================================================
  // fields
  localparam int MODE_AUTO_BIT = 7;
  localparam int MODE_RESTART_BIT = 4;
  localparam int MODE_DIVHI_MSB = 3;
  localparam int CONFIG_EVEN_BIT = 0;
  localparam int CONFIG_FIELD_BIT = 1;
  localparam int CONTROL_START_BIT = 0;
  localparam int CONTROL_STOP_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_ZERO_BIT = 0;
  localparam int IRQ_START_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // types
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } ahb_addr_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] div_low;
    logic [7:0] reload_high;
    logic [7:0] reload_low;
    logic [7:0] config_bits;
    logic [15:0] count;
    logic running;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic irq;
    logic ready;
    ahb_addr_t dphase;
    logic [31:0] rdata;
    logic [13:0] chk_strobes;
    logic chk_valid;
  } timer_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  typedef struct packed {
    logic [ACC_WIDTH-1:0] acc;
    logic strobe;
    logic [12:0] div_count;
    logic tick;
  } prescale_state_t;

endpackage

// File: core/edge_sync.sv
// two-flop synchroniser with rising edge detect for one pin
// assumes the pin level is asynchronous to hclk
`timescale 1ns/1ns
`default_nettype none
module edge_sync
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic rise
);

  sync_state_t s;
  sync_state_t s_next;

  always_comb begin
    s_next = s;
    s_next.s1 = pin;
    s_next.s2 = s.s1;
    s_next.s3 = s.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= s_next;
    end
  end

  // the first flop is seen only by the second
  assign rise = s.s2 & ~s.s3;

endmodule
`default_nettype wire

// File: core/timer_prescaler.sv
// 13.56 MHz reference strobe and programmable tick divider
// assumes restart is a one-cycle pulse from logic on hclk
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  input wire logic [11:0] divider_value,
  input wire logic even_divide_select,
  output logic ref_strobe,
  output logic tick
);

  prescale_state_t s;
  prescale_state_t s_next;
  logic [ACC_WIDTH-1:0] acc_sum;
  logic [12:0] limit;

  always_comb begin
    s_next = s;
    // fractional accumulator: mean rate exact, jitter of one bus clock
    acc_sum = s.acc + REF_STEP;
    s_next.strobe = 1'b0;
    if (acc_sum >= REF_MOD) begin
      acc_sum = acc_sum - REF_MOD;
      s_next.strobe = 1'b1;
    end
    s_next.acc = acc_sum;
    // period is limit+1 reference cycles
    limit = {divider_value, even_divide_select}; // [RULE_02] [RULE_03]
    s_next.tick = 1'b0;
    if (restart) begin
      s_next.div_count = '0;
    end else if (s.strobe) begin
      if (s.div_count >= limit) begin
        s_next.div_count = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.div_count = s.div_count + 13'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= s_next;
    end
  end

  assign ref_strobe = s.strobe;
  assign tick = s.tick;

endmodule
`default_nettype wire

// File: core/prescaled_reload_timer.sv
// prescaled reload down-counter with AHB-Lite register slave and interrupt
// assumes a single AHB-Lite master, word transfers, hready fed back from hreadyout
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// RULE_01: divider value is twelve bits: mode low nibble above divider low byte.
// RULE_02: with even select clear, tick period is twice divider plus one reference cycles.
// RULE_03: with even select set, tick period is twice divider plus two reference cycles.
// RULE_04: reload value is sixteen bits in two read-write byte registers.
// RULE_05: every start event copies the reload value into the counter.
// RULE_06: reload writes leave a running count alone until the next start.
// RULE_07: live counter readable as high and low read-only bytes.
// RULE_08: software must not trust counter contents after reset.
// RULE_09: without auto-restart, count down to zero, stop and raise the timer interrupt.
// RULE_10: with auto-restart, reload at zero and keep counting.
// RULE_11: automatic start at transmit end, or field-on when initial-field-on is set.
// RULE_12: while running, each tick decrements the counter by exactly one.
module prescaled_reload_timer
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_end,
  input wire logic field_on,
  output logic irq
);

  // ==========================================================
  // state
  timer_state_t s;
  timer_state_t s_next;
  logic tx_rise;
  logic field_rise;
  logic ref_strobe;
  logic tick;
  logic start;
  logic stop;
  logic wr;
  logic [7:0] wbyte;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic [11:0] divider_value;
  logic [15:0] reload_value;
  logic auto_restart_enable;
  logic automatic_start_enable;

  function automatic logic [31:0] read_mux(input timer_state_t st, input logic [7:0] idx);
    logic [7:0] b;
    b = RESET_BYTE;
    case (idx)
      IDX_MODE: b = st.mode;
      IDX_DIV_LOW: b = st.div_low;
      IDX_RELOAD_HIGH: b = st.reload_high;
      IDX_RELOAD_LOW: b = st.reload_low;
      IDX_COUNT_HIGH: b = st.count[15:8]; // [RULE_07]
      IDX_COUNT_LOW: b = st.count[7:0]; // [RULE_07]
      IDX_CONFIG: b = st.config_bits;
      IDX_CONTROL: b = {7'h00, st.running};
      IDX_IRQ_STATUS: b = {6'h00, st.irq_status};
      IDX_IRQ_MASK: b = {6'h00, st.irq_mask};
      default: b = RESET_BYTE;
    endcase
    return {24'h000000, b};
  endfunction

  // ==========================================================
  // pins and prescaler
  edge_sync u_tx_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(tx_end),
    .rise(tx_rise)
  );

  edge_sync u_field_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(field_on),
    .rise(field_rise)
  );

  assign divider_value = {s.mode[MODE_DIVHI_MSB:0], s.div_low}; // [RULE_01]
  assign reload_value = {s.reload_high, s.reload_low}; // [RULE_04]
  assign auto_restart_enable = s.mode[MODE_RESTART_BIT];
  assign automatic_start_enable = s.mode[MODE_AUTO_BIT];

  timer_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(start),
    .divider_value(divider_value),
    .even_divide_select(s.config_bits[CONFIG_EVEN_BIT]),
    .ref_strobe(ref_strobe),
    .tick(tick)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_next = s;
    wr = s.dphase.valid & s.dphase.write;
    wbyte = hwdata[7:0];
    start = 1'b0;
    stop = 1'b0;
    irq_set = '0;
    irq_clear = '0;
    // register writes land in the data phase
    if (wr) begin
      case (s.dphase.index)
        IDX_MODE: s_next.mode = wbyte;
        IDX_DIV_LOW: s_next.div_low = wbyte;
        IDX_RELOAD_HIGH: s_next.reload_high = wbyte; // [RULE_04] [RULE_06]
        IDX_RELOAD_LOW: s_next.reload_low = wbyte; // [RULE_04] [RULE_06]
        IDX_CONFIG: s_next.config_bits = wbyte;
        IDX_CONTROL: begin
          start = wbyte[CONTROL_START_BIT];
          stop = wbyte[CONTROL_STOP_BIT];
        end
        IDX_IRQ_STATUS: irq_clear = wbyte[IRQ_WIDTH-1:0];
        IDX_IRQ_MASK: s_next.irq_mask = wbyte[IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    if (automatic_start_enable) begin
      if (tx_rise || (field_rise && s.config_bits[CONFIG_FIELD_BIT])) begin
        start = 1'b1; // [RULE_11]
      end
    end
    // start beats stop, stop beats a tick
    if (start) begin
      s_next.count = reload_value; // [RULE_05]
      s_next.running = 1'b1;
      irq_set[IRQ_START_BIT] = 1'b1;
    end else if (stop) begin
      s_next.running = 1'b0;
    end else if (s.running && tick) begin
      if (s.count <= COUNT_ONE) begin
        irq_set[IRQ_ZERO_BIT] = 1'b1; // [RULE_09]
        if (auto_restart_enable) begin
          s_next.count = reload_value; // [RULE_10]
        end else begin
          s_next.count = '0; // [RULE_09]
          s_next.running = 1'b0;
        end
      end else begin
        s_next.count = s.count - COUNT_ONE; // [RULE_12]
      end
    end
    // set wins over a write-one clear in the same cycle
    s_next.irq_status = (s.irq_status & ~irq_clear) | irq_set;
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    // address phase; read data from next state so a write just before is seen
    s_next.ready = 1'b1;
    // nonseq and seq start a transfer; idle and busy slots carry none
    s_next.dphase.valid = hsel & hready & htrans[1];
    s_next.dphase.write = hwrite;
    s_next.dphase.index = haddr[ADDR_MSB:ADDR_LSB];
    if (s_next.dphase.valid && !hwrite) begin
      s_next.rdata = read_mux(s_next, haddr[ADDR_MSB:ADDR_LSB]);
    end
    // checker helper: reference strobes since the last tick or restart
    if (start) begin
      s_next.chk_strobes = '0;
      s_next.chk_valid = 1'b1;
    end else if (tick) begin
      s_next.chk_strobes = '0;
      s_next.chk_valid = 1'b1;
    end else if (ref_strobe) begin
      s_next.chk_strobes = s.chk_strobes + 14'h0001;
    end
    if (wr && (s.dphase.index == IDX_MODE || s.dphase.index == IDX_DIV_LOW
        || s.dphase.index == IDX_CONFIG)) begin
      s_next.chk_valid = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= s_next;
    end
  end

  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign irq = s.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_divider_join: assert property ( // [RULE_01]
    u_prescaler.divider_value[7:0] == s.div_low
    && u_prescaler.divider_value[11:8] == s.mode[MODE_DIVHI_MSB:0])
    else $error("divider value not formed from both registers");

  a_odd_period: assert property ( // [RULE_02]
    tick && s.chk_valid && !s.config_bits[CONFIG_EVEN_BIT]
    |-> s.chk_strobes == {1'b0, divider_value, 1'b1})
    else $error("odd divide period wrong");

  a_even_period: assert property ( // [RULE_03]
    tick && s.chk_valid && s.config_bits[CONFIG_EVEN_BIT]
    |-> s.chk_strobes == {1'b0, divider_value, 1'b0} + 14'h0002)
    else $error("even divide period wrong");

  a_reload_store: assert property ( // [RULE_04]
    wr && s.dphase.index == IDX_RELOAD_LOW |=> s.reload_low == $past(hwdata[7:0]))
    else $error("reload low byte not stored");

  a_start_load: assert property ( // [RULE_05]
    start |=> s.running && s.count == $past(reload_value))
    else $error("start did not load reload value");

  a_reload_quiet: assert property ( // [RULE_06]
    s.running && !start && !tick && !stop |=> s.count == $past(s.count))
    else $error("count moved without tick or start");

  a_count_read: assert property ( // [RULE_07]
    s_next.dphase.valid && !hwrite && haddr[ADDR_MSB:ADDR_LSB] == IDX_COUNT_HIGH
    |=> hrdata == {24'h000000, $past(s_next.count[15:8])})
    else $error("count high byte read wrong");

  a_zero_stop: assert property ( // [RULE_09]
    s.running && tick && !start && !stop && s.count <= COUNT_ONE && !auto_restart_enable
    |=> !s.running && s.count == '0 && s.irq_status[IRQ_ZERO_BIT])
    else $error("timer did not stop at zero with interrupt");

  a_auto_reload: assert property ( // [RULE_10]
    s.running && tick && !start && !stop && s.count <= COUNT_ONE && auto_restart_enable
    |=> s.running && s.count == $past(reload_value))
    else $error("auto-restart did not reload");

  a_auto_start: assert property ( // [RULE_11]
    automatic_start_enable && tx_rise |=> s.running)
    else $error("automatic start missed");

  a_tick_step: assert property ( // [RULE_12]
    s.running && tick && !start && !stop && s.count > COUNT_ONE
    |=> s.count == $past(s.count) - COUNT_ONE)
    else $error("count did not step by one");

  a_irq_level: assert property (
    s.irq_status[IRQ_ZERO_BIT] && s.irq_mask[IRQ_ZERO_BIT] && !wr |=> irq)
    else $error("unmasked status did not raise irq");

  a_status_sticky: assert property (
    s.irq_status[IRQ_ZERO_BIT] && !wr |=> s.irq_status[IRQ_ZERO_BIT])
    else $error("zero flag dropped without a clear");

  // ==========================================================
  // bus assertions

  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low outside reset");

  a_no_request: assert property (!hsel || !htrans[1] |=> !s.dphase.valid)
    else $error("data phase without a transfer");

  a_read_hold: assert property (!(s_next.dphase.valid && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");

  a_read_upper: assert property (s_next.dphase.valid && !hwrite |=> hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // ==========================================================
  // register and timer assertions

  a_mode_store: assert property ( // [RULE_01]
    wr && s.dphase.index == IDX_MODE
    |=> divider_value[11:8] == $past(hwdata[MODE_DIVHI_MSB:0]))
    else $error("divider high bits not taken from mode write");

  a_div_store: assert property ( // [RULE_01]
    wr && s.dphase.index == IDX_DIV_LOW |=> divider_value[7:0] == $past(hwdata[7:0]))
    else $error("divider low bits not taken from write");

  a_strobe_once: assert property (
    ref_strobe |=> !ref_strobe)
    else $error("reference strobe longer than one cycle");

  a_reload_high: assert property ( // [RULE_04]
    wr && s.dphase.index == IDX_RELOAD_HIGH |=> s.reload_high == $past(hwdata[7:0]))
    else $error("reload high byte not stored");

  a_reload_held: assert property ( // [RULE_06]
    wr && (s.dphase.index == IDX_RELOAD_HIGH || s.dphase.index == IDX_RELOAD_LOW)
    && !start && !tick |=> s.count == $past(s.count))
    else $error("reload write disturbed the count");

  a_count_low: assert property ( // [RULE_07]
    s_next.dphase.valid && !hwrite && haddr[ADDR_MSB:ADDR_LSB] == IDX_COUNT_LOW
    |=> hrdata == {24'h000000, $past(s_next.count[7:0])})
    else $error("count low byte read wrong");

  a_count_ro: assert property ( // [RULE_07]
    wr && s.dphase.index == IDX_COUNT_LOW && !start && !s.running
    |=> s.count == $past(s.count))
    else $error("count byte took a write");

  a_stopped_hold: assert property ( // [RULE_09]
    !s.running && !start |=> s.count == $past(s.count))
    else $error("stopped count moved");

  a_field_start: assert property ( // [RULE_11]
    automatic_start_enable && field_rise && s.config_bits[CONFIG_FIELD_BIT]
    |=> s.running && s.count == $past(reload_value))
    else $error("field-on start missed");

  a_no_auto: assert property ( // [RULE_11]
    !automatic_start_enable && !wr && !s.running |=> !s.running)
    else $error("timer started with automatic start off");

  a_tick_once: assert property ( // [RULE_12]
    tick |=> !tick)
    else $error("tick longer than one cycle");

  a_stop_halts: assert property (
    stop && !start |=> !s.running)
    else $error("stop did not halt the timer");

  a_start_flag: assert property (
    start |=> s.irq_status[IRQ_START_BIT])
    else $error("start event flag not set");

  a_zero_clear: assert property (
    wr && s.dphase.index == IDX_IRQ_STATUS && hwdata[IRQ_ZERO_BIT] && !irq_set[IRQ_ZERO_BIT]
    |=> !s.irq_status[IRQ_ZERO_BIT])
    else $error("write one did not clear zero flag");

  a_irq_quiet: assert property (
    !(|(s.irq_status & s.irq_mask)) && !(|irq_set) && !wr |=> !irq)
    else $error("irq high with nothing unmasked");

endmodule
`default_nettype wire

// File: verification/test_prescaled_reload_timer.sv
// self-checking bench for the prescaled reload timer
// assumes the timer is the only slave, hready looped back from hreadyout
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  $display("wrong value %s exp %h got %h", nm, exp, got); err_total++; end end
module test_prescaled_reload_timer;
  import timer_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_end, field_on, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total, n_tests;
  logic [31:0] rv;

  prescaled_reload_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_end(tx_end),
    .field_on(field_on), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // bus and wait helpers
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // every wait is bounded, a hang ends the run
  task automatic edge_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    edge_rdy();
    rv = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask

  task automatic wait_irq(input int lim, output int cyc);
    cyc = 0;
    while (irq !== 1'b1) begin
      @(posedge hclk);
      cyc++;
      if (cyc > lim) begin
        err_total++;
        stop_test();
      end
    end
  endtask

  task automatic pulse(input logic pin_sel);
    @(posedge hclk);
    if (pin_sel) field_on <= 1'b1;
    else tx_end <= 1'b1;
    repeat (4) @(posedge hclk);
    tx_end <= 1'b0;
    field_on <= 1'b0;
    // sync takes two edges, start lands one later
    repeat (6) @(posedge hclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] idx[8];
    // count bytes left out: no defined value after reset
    idx = '{IDX_MODE, IDX_DIV_LOW, IDX_RELOAD_HIGH, IDX_RELOAD_LOW, IDX_CONFIG,
      IDX_IRQ_MASK, IDX_IRQ_STATUS, 8'h10};
    foreach (idx[i]) begin
      rd(idx[i]);
      `CHK("reset value", 32'h0, rv)
    end
    `CHK("irq idle", 1'b0, irq)
    `CHK("hreadyout", 1'b1, hreadyout)
  endtask

  task automatic t_rw();
    logic [7:0] idx[3];
    logic [31:0] keep;
    idx = '{IDX_DIV_LOW, IDX_RELOAD_HIGH, IDX_RELOAD_LOW};
    foreach (idx[i]) begin
      wr(idx[i], 8'ha5);
      rd(idx[i]);
      `CHK("rw a5", 32'ha5, rv)
      wr(idx[i], 8'h5a);
      rd(idx[i]);
      `CHK("rw 5a", 32'h5a, rv)
    end
    for (int k = 0; k < 2; k++) begin
      rd(IDX_COUNT_HIGH + 8'(k));
      keep = rv;
      wr(IDX_COUNT_HIGH + 8'(k), 8'hff);
      rd(IDX_COUNT_HIGH + 8'(k));
      `CHK("count read only", keep, rv)
    end
  endtask

  // start to interrupt time against the divide formula, then check the stop at zero and clear
  task automatic timed(input logic [11:0] p, input logic ev, input logic [15:0] rl);
    int cyc;
    real ec;
    wr(IDX_MODE, {4'h0, p[11:8]});
    wr(IDX_DIV_LOW, p[7:0]);
    wr(IDX_CONFIG, {7'h0, ev});
    wr(IDX_RELOAD_HIGH, rl[15:8]);
    wr(IDX_RELOAD_LOW, rl[7:0]);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_CONTROL, 8'h01);
    wait_irq(60000, cyc);
    ec = real'(rl) * real'(2 * int'(p) + 1 + int'(ev)) * real'(CLK_FREQ_KHZ)
      / real'(REF_FREQ_KHZ);
    `CHK("tick time", 1'b1, (real'(cyc) > ec - 24.0) && (real'(cyc) < ec + 24.0))
    rd(IDX_CONTROL);
    `CHK("stopped at zero", 32'h0, rv)
    rd(IDX_COUNT_LOW);
    `CHK("count zero", 32'h0, rv)
    rd(IDX_IRQ_STATUS);
    `CHK("status", 32'h3, rv)
    wr(IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
  endtask

  task automatic t_reload();
    wr(IDX_MODE, 8'h00);
    wr(IDX_DIV_LOW, 8'h00);
    wr(IDX_RELOAD_HIGH, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h30);
    wr(IDX_CONTROL, 8'h01);
    rd(IDX_COUNT_LOW);
    `CHK("loaded", 1'b1, rv >= 32'h2e && rv <= 32'h30)
    wr(IDX_RELOAD_LOW, 8'h90);
    rd(IDX_COUNT_LOW);
    `CHK("running undisturbed", 1'b1, rv >= 32'h2a && rv <= 32'h30)
    wr(IDX_CONTROL, 8'h01);
    rd(IDX_COUNT_HIGH);
    `CHK("new reload high", 32'h0, rv)
    rd(IDX_COUNT_LOW);
    `CHK("new reload", 1'b1, rv >= 32'h8d && rv <= 32'h90)
    wr(IDX_CONTROL, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h03);
  endtask

  task automatic t_restart();
    int cyc;
    wr(IDX_MODE, 8'h10);
    wr(IDX_RELOAD_LOW, 8'h02);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CONTROL, 8'h01);
    wait_irq(200, cyc);
    rd(IDX_CONTROL);
    `CHK("still running", 32'h1, rv)
    rd(IDX_COUNT_LOW);
    `CHK("reloaded", 1'b1, rv >= 32'h1 && rv <= 32'h2)
    wr(IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge hclk);
    wait_irq(200, cyc);
    wr(IDX_CONTROL, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h03);
  endtask

  task automatic t_auto();
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_MODE, 8'h80);
    wr(IDX_CONFIG, 8'h00);
    pulse(1'b0);
    rd(IDX_CONTROL);
    `CHK("start on tx end", 32'h1, rv)
    `CHK("start masked", 1'b0, irq)
    wr(IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge hclk);
    `CHK("start unmasked", 1'b1, irq)
    wr(IDX_CONTROL, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge hclk);
    `CHK("start cleared", 1'b0, irq)
    pulse(1'b1);
    rd(IDX_CONTROL);
    `CHK("field ignored", 32'h0, rv)
    wr(IDX_CONFIG, 8'h02);
    pulse(1'b1);
    rd(IDX_CONTROL);
    `CHK("start on field", 32'h1, rv)
    wr(IDX_CONTROL, 8'h02);
    wr(IDX_MODE, 8'h00);
    pulse(1'b0);
    rd(IDX_CONTROL);
    `CHK("auto off", 32'h0, rv)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tx_end = 1'b0;
    field_on = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_rw();
    timed(12'h000, 1'b0, 16'h0003);
    timed(12'h100, 1'b0, 16'h0002);
    timed(12'h003, 1'b1, 16'h0028);
    t_reload();
    t_restart();
    t_auto();
    stop_test();
  end
endmodule
`default_nettype wire
